// file: hdl/twe_consts.svh
// Purpose: Shared constants of the two-wire 1K-bit serial memory slave.
// Assumes: ref_clk runs at 100 MHz.
// Notes: Shared figures are named here; code also uses literal slot and bit indices such as addr[1:0].
`ifndef TWE_CONSTS_SVH
`define TWE_CONSTS_SVH

// Array geometry
`define TWE_ADDR_W 7
`define TWE_DATA_W 8
`define TWE_ROW_LSB 2
`define TWE_PAGE_BYTES 4
`define TWE_ERASED 8'hff

// Bit counting within a byte
`define TWE_BYTE_BITS 4'h8
`define TWE_TX_LAST 4'h7

// Program cycle timing
`define TWE_CLK_MHZ 100
`define TWE_PROG_TIME_MS 10
`define TWE_PROG_CYCLES (`TWE_PROG_TIME_MS * 1000 * `TWE_CLK_MHZ)
`define TWE_PROG_CNT_W 20

`endif

// file: hdl/twe_pkg.sv
// Purpose: Types of the two-wire serial memory slave.
// Assumes: twe_consts.svh supplies widths.
// Notes: Controller state is a single packed struct.
`include "twe_consts.svh"

package twe_pkg;

	typedef enum logic [2:0] {
		TWE_IDLE,
		TWE_ADDR,
		TWE_ADDR_ACK,
		TWE_WDATA,
		TWE_WDATA_ACK,
		TWE_RDATA,
		TWE_RACK,
		TWE_PROG
	} twe_state_e;

	typedef logic [`TWE_ADDR_W-1:0] twe_addr_t;
	typedef logic [`TWE_DATA_W-1:0] twe_byte_t;

	typedef struct packed {
		logic scl_meta;
		logic scl_sync;
		logic scl_old;
		logic sda_meta;
		logic sda_sync;
		logic sda_old;
		logic wp_meta;
		logic wp_sync;
		twe_state_e st;
		logic [3:0] cnt;
		twe_byte_t shift;
		twe_addr_t addr;
		logic rd_dir;
		logic wp_seen;
		logic acked;
		logic [`TWE_PAGE_BYTES-1:0][`TWE_DATA_W-1:0] page;
		logic [`TWE_PAGE_BYTES-1:0] page_vld;
		logic [`TWE_PROG_CNT_W-1:0] prog_cnt;
		logic mem_we;
		twe_addr_t mem_waddr;
		twe_byte_t mem_wdata;
		logic sda_o;
		logic sda_oe;
		logic busy;
	} twe_ctrl_s;

endpackage : twe_pkg

// file: hdl/twe_mem_if.sv
// Purpose: Port bundle between the bus controller and the storage array.
// Assumes: One write port and one registered read port.
// Notes: Read data lag the read address by one clock.
`timescale 1ns/100ps

interface twe_mem_if;
	import twe_pkg::*;

	logic we;
	twe_addr_t waddr;
	twe_byte_t wdata;
	twe_addr_t raddr;
	twe_byte_t rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);

endinterface : twe_mem_if

// file: hdl/twe_mem.sv
// Purpose: 128 x 8 storage array with registered read data.
// Assumes: Writes come only from the program cycle of the controller.
// Notes: Content is not cleared by reset, as nonvolatile storage would not be.
`timescale 1ns/100ps
`include "twe_consts.svh"

module twe_mem (
	// Clock
	input wire logic ref_clk,
	// Controller side
	twe_mem_if.mem mp
);
	import twe_pkg::*;

	localparam int DEPTH = 1 << `TWE_ADDR_W;

	// Delivered content is erased in every byte; set at declaration so that
	// the clocked write stays the only process writing the array
	twe_byte_t cells [0:DEPTH-1] = '{default: `TWE_ERASED};
	twe_byte_t rd_reg;

	always_ff @(posedge ref_clk) begin
		if (mp.we) begin
			cells[mp.waddr] <= mp.wdata;
		end
		rd_reg <= cells[mp.raddr];
	end

	assign mp.rdata = rd_reg;

endmodule : twe_mem

// file: hdl/twe_eeprom.sv
// Purpose: Slave logic of a 1K-bit two-wire serial memory.
// Assumes: SCL, SDA and write protect are asynchronous pins; ref_clk far faster than SCL.
// Notes: SDA is open drain: the block only ever pulls low or releases.
`timescale 1ns/100ps
`include "twe_consts.svh"

module twe_eeprom #(
	parameter int unsigned PROG_CYCLES = `TWE_PROG_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Write protect pin
	input wire logic write_protect_input,
	// Status
	output logic prog_busy
);
	import twe_pkg::*;

	localparam logic [`TWE_PROG_CNT_W-1:0] PROG_LAST = `TWE_PROG_CNT_W'(PROG_CYCLES - 1);

	twe_ctrl_s r_reg;
	twe_ctrl_s r_next;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	twe_mem_if u_if ();

	twe_mem u_mem (
		.ref_clk(ref_clk),
		.mp(u_if.mem)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus condition decode, from second and third synchroniser stages only

	assign scl_rise = r_reg.scl_sync & ~r_reg.scl_old;
	assign scl_fall = ~r_reg.scl_sync & r_reg.scl_old;
	// SDA moving while SCL stays high marks START or STOP; data edges never do
	assign bus_start = r_reg.scl_sync & r_reg.scl_old & r_reg.sda_old & ~r_reg.sda_sync;
	assign bus_stop = r_reg.scl_sync & r_reg.scl_old & ~r_reg.sda_old & r_reg.sda_sync;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		r_next = r_reg;
		r_next.scl_meta = scl_in;
		r_next.scl_sync = r_reg.scl_meta;
		r_next.scl_old = r_reg.scl_sync;
		r_next.sda_meta = sda_in;
		r_next.sda_sync = r_reg.sda_meta;
		r_next.sda_old = r_reg.sda_sync;
		// Pull-down on the pin keeps an open input low
		r_next.wp_meta = write_protect_input;
		r_next.wp_sync = r_reg.wp_meta;
		r_next.mem_we = 1'b0;
		r_next.sda_o = 1'b0;
		case (r_reg.st)
			TWE_IDLE: begin
				r_next.sda_oe = 1'b0;
			end
			TWE_ADDR: begin
				// Protection is sticky across START through the address byte
				r_next.wp_seen = r_reg.wp_seen | r_reg.wp_sync;
				if (scl_rise) begin
					r_next.shift = {r_reg.shift[6:0], r_reg.sda_sync};
					r_next.cnt = r_reg.cnt + 4'h1;
				end else if (scl_fall && r_reg.cnt == `TWE_BYTE_BITS) begin
					r_next.addr = r_reg.shift[7:1];
					r_next.rd_dir = r_reg.shift[0];
					r_next.page_vld = '0;
					r_next.sda_oe = 1'b1;
					r_next.st = TWE_ADDR_ACK;
				end
			end
			TWE_ADDR_ACK: begin
				if (scl_fall) begin
					r_next.cnt = 4'h0;
					if (r_reg.rd_dir) begin
						// Read data are ready long before the ninth clock ends
						r_next.shift = u_if.rdata;
						r_next.sda_oe = ~u_if.rdata[7];
						r_next.st = TWE_RDATA;
					end else begin
						r_next.sda_oe = 1'b0;
						r_next.st = TWE_WDATA;
					end
				end
			end
			TWE_WDATA: begin
				if (scl_rise) begin
					r_next.shift = {r_reg.shift[6:0], r_reg.sda_sync};
					r_next.cnt = r_reg.cnt + 4'h1;
				end else if (scl_fall && r_reg.cnt == `TWE_BYTE_BITS) begin
					// Overrunning a row lands on an earlier slot of the page
					r_next.page[r_reg.addr[1:0]] = r_reg.shift;
					r_next.page_vld[r_reg.addr[1:0]] = ~r_reg.wp_seen;
					r_next.addr = {r_reg.addr[`TWE_ADDR_W-1:`TWE_ROW_LSB],
						r_reg.addr[1:0] + 2'h1};
					r_next.sda_oe = ~r_reg.wp_seen;
					r_next.st = TWE_WDATA_ACK;
				end
			end
			TWE_WDATA_ACK: begin
				if (scl_fall) begin
					r_next.sda_oe = 1'b0;
					r_next.cnt = 4'h0;
					r_next.st = TWE_WDATA;
				end
			end
			TWE_RDATA: begin
				if (scl_fall) begin
					if (r_reg.cnt == `TWE_TX_LAST) begin
						r_next.sda_oe = 1'b0;
						r_next.addr = r_reg.addr + 7'h01;
						r_next.acked = 1'b0;
						r_next.st = TWE_RACK;
					end else begin
						r_next.shift = {r_reg.shift[6:0], 1'b0};
						r_next.cnt = r_reg.cnt + 4'h1;
						r_next.sda_oe = ~r_reg.shift[6];
					end
				end
			end
			TWE_RACK: begin
				if (scl_rise) begin
					if (r_reg.sda_sync) begin
						r_next.st = TWE_IDLE;
					end else begin
						r_next.acked = 1'b1;
					end
				end else if (scl_fall && r_reg.acked) begin
					r_next.shift = u_if.rdata;
					r_next.sda_oe = ~u_if.rdata[7];
					r_next.cnt = 4'h0;
					r_next.st = TWE_RDATA;
				end
			end
			TWE_PROG: begin
				// Page slots are copied in the first cycles; the rest is dead time
				r_next.sda_oe = 1'b0;
				r_next.prog_cnt = r_reg.prog_cnt + `TWE_PROG_CNT_W'(1);
				if (r_reg.prog_cnt[`TWE_PROG_CNT_W-1:2] == '0) begin
					r_next.mem_we = r_reg.page_vld[r_reg.prog_cnt[1:0]];
					r_next.mem_waddr = {r_reg.addr[`TWE_ADDR_W-1:`TWE_ROW_LSB],
						r_reg.prog_cnt[1:0]};
					r_next.mem_wdata = r_reg.page[r_reg.prog_cnt[1:0]];
				end
				if (r_reg.prog_cnt == PROG_LAST) begin
					r_next.prog_cnt = '0;
					r_next.st = TWE_IDLE;
				end
			end
			default: begin
				r_next.sda_oe = 1'b0;
				r_next.st = TWE_IDLE;
			end
		endcase
		// Bus conditions win over bit handling, except while deaf
		if (r_reg.st != TWE_PROG) begin
			if (bus_start) begin
				r_next.sda_oe = 1'b0;
				r_next.cnt = 4'h0;
				r_next.wp_seen = r_reg.wp_sync;
				r_next.st = TWE_ADDR;
			end else if (bus_stop) begin
				r_next.sda_oe = 1'b0;
				if ((r_reg.st == TWE_WDATA || r_reg.st == TWE_WDATA_ACK) && |r_reg.page_vld) begin
					r_next.prog_cnt = '0;
					r_next.st = TWE_PROG;
				end else begin
					r_next.st = TWE_IDLE;
				end
			end
		end
		r_next.busy = (r_next.st == TWE_PROG);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs and array port

	assign sda_out = r_reg.sda_o;
	assign sda_oe = r_reg.sda_oe;
	assign prog_busy = r_reg.busy;

	assign u_if.we = r_reg.mem_we;
	assign u_if.waddr = r_reg.mem_waddr;
	assign u_if.wdata = r_reg.mem_wdata;
	assign u_if.raddr = r_reg.addr;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	a_stop_read_idle: assert property (
		bus_stop && (r_reg.st == TWE_RDATA || r_reg.st == TWE_RACK) |=> r_reg.st == TWE_IDLE
	) else $error("stop during read did not return to standby");

	a_stop_write_prog: assert property (
		bus_stop && (r_reg.st == TWE_WDATA || r_reg.st == TWE_WDATA_ACK) && |r_reg.page_vld
		|=> r_reg.st == TWE_PROG && r_reg.busy
	) else $error("stop after write did not start program cycle");

	a_stop_release: assert property (
		bus_stop && r_reg.st != TWE_PROG |=> !r_reg.sda_oe
	) else $error("sda still pulled after stop");

	a_addr_ack: assert property (
		r_reg.st == TWE_ADDR && scl_fall && r_reg.cnt == `TWE_BYTE_BITS
		|=> r_reg.sda_oe && r_reg.st == TWE_ADDR_ACK
	) else $error("address byte not acknowledged");

	a_ack_release: assert property (
		r_reg.st == TWE_WDATA_ACK && scl_fall && !bus_start && !bus_stop
		|=> !r_reg.sda_oe && r_reg.cnt == 4'h0
	) else $error("sda not released after ninth clock");

	a_write_dir: assert property (
		r_reg.st == TWE_ADDR_ACK && scl_fall && !r_reg.rd_dir && !bus_start && !bus_stop
		|=> r_reg.st == TWE_WDATA
	) else $error("write direction did not await data");

	a_wp_no_ack: assert property (
		r_reg.st == TWE_WDATA && scl_fall && r_reg.cnt == `TWE_BYTE_BITS && r_reg.wp_seen
		|=> !r_reg.sda_oe && r_next.page_vld == $past(r_reg.page_vld)
	) else $error("protected data byte was acknowledged or kept");

	a_rise_sample: assert property (
		r_reg.st == TWE_ADDR && scl_rise && !bus_start && !bus_stop
		|=> r_reg.shift[0] == $past(r_reg.sda_sync)
	) else $error("bit not captured on scl rise");

	a_page_row: assert property (
		r_reg.st == TWE_WDATA && scl_fall && r_reg.cnt == `TWE_BYTE_BITS
		|=> r_reg.addr[`TWE_ADDR_W-1:`TWE_ROW_LSB] == $past(r_reg.addr[`TWE_ADDR_W-1:`TWE_ROW_LSB])
		&& r_reg.addr[1:0] == $past(r_reg.addr[1:0]) + 2'h1
	) else $error("page address left its row");

	a_read_incr: assert property (
		r_reg.st == TWE_RDATA && scl_fall && r_reg.cnt == `TWE_TX_LAST && !bus_start && !bus_stop
		|=> r_reg.addr == $past(r_reg.addr) + 7'h01 && !r_reg.sda_oe
	) else $error("read address did not advance");

	a_nack_idle: assert property (
		r_reg.st == TWE_RACK && scl_rise && r_reg.sda_sync && !bus_start && !bus_stop
		|=> r_reg.st == TWE_IDLE ##1 !r_reg.sda_oe
	) else $error("missing master ack did not end read");

	a_prog_deaf: assert property (
		r_reg.st == TWE_PROG && r_reg.prog_cnt != PROG_LAST |=> r_reg.st == TWE_PROG && !r_reg.sda_oe
	) else $error("program cycle ended early or answered the bus");

	a_prog_end: assert property (
		r_reg.st == TWE_PROG && r_reg.prog_cnt == PROG_LAST |=> r_reg.st == TWE_IDLE && !r_reg.busy
	) else $error("program cycle overran its time");

	a_write_only_prog: assert property (
		r_reg.mem_we |-> $past(r_reg.st) == TWE_PROG && $past(r_reg.prog_cnt) < 4
	) else $error("array written outside program cycle");

	a_start_addr: assert property (
		bus_start && r_reg.st != TWE_PROG |=> r_reg.st == TWE_ADDR && r_reg.cnt == 4'h0
	) else $error("start not recognised");

	a_wp_sticky: assert property (
		r_reg.st == TWE_ADDR && r_reg.wp_sync |=> r_reg.wp_seen
	) else $error("write protect during address byte was lost");

	a_read_msb: assert property (
		r_reg.st == TWE_ADDR_ACK && scl_fall && r_reg.rd_dir
		|=> r_reg.st == TWE_RDATA && r_reg.sda_oe == ~$past(u_if.rdata[7])
	) else $error("first read bit not driven after address ack");

	a_seq_next: assert property (
		r_reg.st == TWE_RACK && r_reg.acked && scl_fall
		|=> r_reg.st == TWE_RDATA && r_reg.cnt == 4'h0
	) else $error("master ack did not start the next byte");

	a_sync_chain: assert property (
		r_reg.sda_sync == $past(r_reg.sda_meta) && r_reg.scl_sync == $past(r_reg.scl_meta)
	) else $error("pin synchroniser skipped a stage");

	c_byte_write: cover property (
		r_reg.st == TWE_WDATA && bus_stop ##1 r_reg.st == TWE_PROG
	);
	c_seq_read: cover property (
		r_reg.st == TWE_RACK && r_reg.acked ##[1:1000] r_reg.st == TWE_RDATA
	);
	c_nack_end: cover property (
		r_reg.st == TWE_RACK ##1 r_reg.st == TWE_IDLE
	);
	c_wp_write: cover property (
		r_reg.st == TWE_WDATA_ACK && r_reg.wp_seen
	);
	c_read_stop: cover property (
		r_reg.st == TWE_RDATA && bus_stop ##1 r_reg.st == TWE_IDLE
	);

endmodule : twe_eeprom

// file: tb/twe_bus_master.sv
// Purpose: Two-wire bus master model that clocks the serial memory.
// Assumes: SDA has a pull-up; SCL stands high between frames.
// Notes: One SCL period is 8 ref_clk; slow stretches the low phase.
`timescale 1ns/100ps

module twe_bus_master (
	// Clock
	input wire logic ref_clk,
	// Bus wires
	input wire logic sda_wire,
	output logic scl,
	output logic sda_pull
);
	int slow = 0;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// Entered just after SCL fell; leaves just after the next fall
	task automatic clock_bit(input logic b, output logic seen);
		tick(2 + slow);
		sda_pull = ~b;
		tick(2);
		scl = 1'b1;
		tick(2);
		seen = sda_wire;
		tick(2);
		scl = 1'b0;
	endtask : clock_bit

	// Also serves as repeated start from mid-frame
	task automatic start();
		if (scl == 1'b0) begin
			tick(2);
			sda_pull = 1'b0;
			tick(2);
			scl = 1'b1;
		end
		tick(4);
		sda_pull = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask : start

	task automatic stop();
		tick(2);
		sda_pull = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_pull = 1'b0;
		tick(8);
	endtask : stop

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, d[i]);
		end
		clock_bit(~ack, s);
	endtask : recv_byte
endmodule : twe_bus_master

// file: tb/two_wire_eeprom_slave_1k_tb.sv
// Purpose: Self-checking bench of the two-wire serial memory slave.
// Assumes: Program cycle shortened to PROG clocks.
// Notes: Bus wire is resolved here from both open-drain pulls.
`timescale 1ns/100ps

module two_wire_eeprom_slave_1k_tb;
	localparam int unsigned PROG = 200;
	localparam int LIMIT = 20000;
	logic ref_clk;
	logic srst = 1'b1;
	logic write_protect_input = 1'b0;
	logic scl_in;
	logic sda_pull;
	logic sda_in;
	logic sda_out;
	logic sda_oe;
	logic prog_busy;
	logic ack;
	logic [7:0] rd;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int busy_len = 0;
	int nacks;

	assign sda_in = ~((sda_oe & ~sda_out) | sda_pull);

	twe_eeprom #(.PROG_CYCLES(PROG)) dut (.ref_clk, .srst, .scl_in, .sda_in, .sda_out,
		.sda_oe, .write_protect_input, .prog_busy);
	twe_bus_master master (.ref_clk, .sda_wire(sda_in), .scl(scl_in), .sda_pull);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (prog_busy === 1'b1) busy_len <= busy_len + 1;
		if (sda_oe === 1'b1) check({7'h00, sda_out}, 8'h00);
		if (cycles == LIMIT) begin
			fail_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic complete_run();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	task automatic frame(input logic [6:0] a, input logic rw, input logic exp);
		master.start();
		master.send_byte({a, rw}, ack);
		check({7'h00, ack}, {7'h00, exp});
	endtask : frame

	// Repeats START plus read byte until acknowledged
	task automatic poll_read(input logic [6:0] a);
		nacks = 0;
		do begin
			master.start();
			master.send_byte({a, 1'b1}, ack);
			if (ack !== 1'b1) nacks++;
		end while (ack !== 1'b1 && nacks < 40);
	endtask : poll_read

	task automatic write_one(input logic [6:0] a, input logic [7:0] d);
		frame(a, 1'b0, 1'b1);
		master.send_byte(d, ack);
		check({7'h00, ack}, 8'h01);
		busy_len = 0;
		master.stop();
		check({7'h00, prog_busy}, 8'h01);
	endtask : write_one

	////////////////////////////////////////////////////////////////////////////////
	// Acked read then STOP: the next byte is dropped and the device stands by
	task automatic t_erased();
		frame(7'h10, 1'b1, 1'b1);
		master.recv_byte(1'b1, rd);
		check(rd, 8'hff);
		master.stop();
		check({6'h00, prog_busy, sda_oe}, 8'h00);
	endtask : t_erased

	task automatic t_byte_write();
		write_one(7'h12, 8'h55);
		poll_read(7'h12);
		check({7'h00, nacks > 0}, 8'h01);
		master.recv_byte(1'b0, rd);
		check(rd, 8'h55);
		master.stop();
		check(8'(busy_len), 8'(PROG));
	endtask : t_byte_write

	task automatic t_page_write();
		logic [7:0] exp [5] = '{8'ha4, 8'ha5, 8'ha2, 8'ha3, 8'hff};
		master.slow = 6;
		frame(7'h21, 1'b0, 1'b1);
		for (int i = 1; i <= 5; i++) begin
			master.send_byte(8'ha0 + 8'(i), ack);
			check({7'h00, ack}, 8'h01);
		end
		master.stop();
		master.slow = 0;
		poll_read(7'h20);
		for (int i = 0; i < 5; i++) begin
			master.recv_byte(i < 4, rd);
			check(rd, exp[i]);
		end
		master.stop();
	endtask : t_page_write

	task automatic t_wrap();
		write_one(7'h7f, 8'h3c);
		poll_read(7'h7f);
		master.recv_byte(1'b1, rd);
		check(rd, 8'h3c);
		master.recv_byte(1'b0, rd);
		check(rd, 8'hff);
		master.stop();
	endtask : t_wrap

	// Protection held across START, then raised only inside the address byte
	task automatic t_protect();
		write_protect_input = 1'b1;
		master.start();
		write_protect_input = 1'b0;
		master.send_byte(8'h60, ack);
		check({7'h00, ack}, 8'h01);
		master.send_byte(8'h11, ack);
		check({7'h00, ack}, 8'h00);
		master.stop();
		check({7'h00, prog_busy}, 8'h00);
		master.start();
		write_protect_input = 1'b1;
		master.tick(4);
		write_protect_input = 1'b0;
		master.send_byte(8'h60, ack);
		check({7'h00, ack}, 8'h01);
		master.send_byte(8'h22, ack);
		check({7'h00, ack}, 8'h00);
		master.stop();
		check({7'h00, prog_busy}, 8'h00);
		frame(7'h30, 1'b1, 1'b1);
		master.recv_byte(1'b0, rd);
		check(rd, 8'hff);
		master.stop();
	endtask : t_protect

	task automatic t_abandon();
		frame(7'h40, 1'b0, 1'b1);
		master.send_byte(8'h77, ack);
		check({7'h00, ack}, 8'h01);
		frame(7'h40, 1'b1, 1'b1);
		master.recv_byte(1'b0, rd);
		check(rd, 8'hff);
		master.stop();
		check({7'h00, prog_busy}, 8'h00);
		master.send_byte(8'h81, ack);
		check({7'h00, ack}, 8'h00);
		master.stop();
	endtask : t_abandon

	initial begin
		master.tick(16);
		srst = 1'b0;
		master.tick(8);
		t_erased();
		t_byte_write();
		t_page_write();
		t_wrap();
		t_protect();
		t_abandon();
		complete_run();
	end
endmodule : two_wire_eeprom_slave_1k_tb
